/* hw/vpecs_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vpecs_defines.svh"
module vpecs_regs #(
    parameter int NUM_VPE = 2,
    parameter int QUAL_INPUTS = `VPECS_QUAL_INPUTS,
    parameter logic [7:0] UDI_PRESET = `VPECS_UDI_PRESET,
    parameter logic [7:0] COP2_PRESET = `VPECS_COP2_PRESET,
    parameter logic [7:0] COP1_PRESET = `VPECS_COP1_PRESET,
    localparam int VW = (NUM_VPE > 1) ? $clog2(NUM_VPE) : 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register access, five registers at selects 3 to 7
    input wire vpecs_pkg::vpecs_acc_t acc,
    input wire logic [VW-1:0] acc_vpe,
    input wire logic config_write_enable,
    output logic [31:0] rdata,
    output logic rd_valid,
    // thread_instr_a qualifier check
    input wire logic thread_instr_a_valid,
    input wire logic [VW-1:0] thread_instr_a_vpe,
    input wire logic [31:0] source_operand,
    output logic thread_exc,
    output logic [3:0] thread_exc_cause,
    // scheduler
    input wire logic [NUM_VPE-1:0] retire_inc,
    input wire logic [VW-1:0] thread_vpe,
    input wire logic [7:0] thread_sched_hint,
    output logic [7:0] thread_issue_share,
    output logic [NUM_VPE*32-1:0] sched_hint,
    // cache way allocation
    output logic [NUM_VPE*8-1:0] icache_way_exclude,
    output logic [NUM_VPE*8-1:0] dcache_way_exclude
);
    if (NUM_VPE < 1 || NUM_VPE > 16 || QUAL_INPUTS < 0 || QUAL_INPUTS > 31) begin : g_bad_params
        $error("vpecs_regs: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per virtual processor copies
    vpecs_pkg::vpecs_regs_t regs [NUM_VPE];

    for (genvar g = 0; g < NUM_VPE; g++) begin : g_vpe
        vpecs_vpe_slice #(
            .QUAL_INPUTS(QUAL_INPUTS),
            .UDI_PRESET(UDI_PRESET),
            .COP2_PRESET(COP2_PRESET),
            .COP1_PRESET(COP1_PRESET)
        ) u_slice (
            .sys_clk(sys_clk),
            .srst(srst),
            .wr_en(acc.wr_en && acc_vpe == VW'(g)),
            .sel(acc.sel),
            .wdata(acc.wdata),
            .config_write_enable(config_write_enable),
            .retire_inc(retire_inc[g]),
            .regs(regs[g])
        );
        assign sched_hint[g*32 +: 32] = regs[g].sched_hint;
        assign icache_way_exclude[g*8 +: 8] = regs[g].cache_way_options[15:8];
        assign dcache_way_exclude[g*8 +: 8] = regs[g].cache_way_options[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux, thread_instr_a check, issue share
    vpecs_pkg::vpecs_top_t state;
    vpecs_pkg::vpecs_top_t next_state;
    vpecs_pkg::vpecs_regs_t rsel;
    vpecs_pkg::vpecs_regs_t ysel;
    vpecs_pkg::vpecs_regs_t tsel;
    logic [7:0] vpe_share;
    logic [15:0] prod;

    always_comb begin
        rsel = regs[0];
        ysel = regs[0];
        tsel = regs[0];
        for (int i = 0; i < NUM_VPE; i++) begin
            if (acc_vpe == VW'(i)) begin
                rsel = regs[i];
            end
            if (thread_instr_a_vpe == VW'(i)) begin
                ysel = regs[i];
            end
            if (thread_vpe == VW'(i)) begin
                tsel = regs[i];
            end
        end
    end

    always_comb begin
        next_state = state;
        next_state.rd_valid = acc.rd_en;
        if (acc.rd_en) begin
            case (acc.sel)
                `VPECS_SEL_CONFIG: begin
                    next_state.rdata = {4'h0, rsel.udi_context_count, 2'h0,
                        rsel.cop2_context_count, 2'h0, rsel.cop1_context_count};
                end
                `VPECS_SEL_THREAD_INSTR_A_QUALIFIER_MASK: next_state.rdata = {1'b0, rsel.thread_instr_a_qualifier_mask};
                `VPECS_SEL_HINT: next_state.rdata = rsel.sched_hint;
                `VPECS_SEL_FBACK: next_state.rdata = rsel.sched_feedback;
                `VPECS_SEL_OPT: next_state.rdata = {16'h0000, rsel.cache_way_options};
                default: next_state.rdata = 32'h00000000;
            endcase
        end
        // positive operand naming a bit outside the mask traps
        next_state.exc = thread_instr_a_valid && !source_operand[31] &&
            ((source_operand[30:0] & ~ysel.thread_instr_a_qualifier_mask) != 31'h00000000);
        next_state.cause = next_state.exc ? `VPECS_CAUSE_QUAL : 4'h0;
        // zero hint means full default share
        vpe_share = (tsel.sched_hint[7:0] == 8'h00) ? `VPECS_SHARE_FULL : tsel.sched_hint[7:0];
        prod = vpe_share * thread_sched_hint;
        next_state.share = prod[15:8];
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign rd_valid = state.rd_valid;
    assign thread_exc = state.exc;
    assign thread_exc_cause = state.cause;
    assign thread_issue_share = state.share;
endmodule // vpecs_regs
`default_nettype wire

/* hw/vpecs_defines.svh */
`ifndef VPECS_DEFINES_SVH
`define VPECS_DEFINES_SVH
`define VPECS_SEL_CONFIG 3'h3
`define VPECS_SEL_THREAD_INSTR_A_QUALIFIER_MASK 3'h4
`define VPECS_SEL_HINT 3'h5
`define VPECS_SEL_FBACK 3'h6
`define VPECS_SEL_OPT 3'h7
`define VPECS_UDI_LSB 20
`define VPECS_COP2_LSB 10
`define VPECS_COP1_LSB 0
`define VPECS_OPT_W 16
`define VPECS_YQ_W 31
`define VPECS_CAUSE_QUAL 4'h3
`define VPECS_QUAL_INPUTS 31
`define VPECS_UDI_PRESET 8'h01
`define VPECS_COP2_PRESET 8'h01
`define VPECS_COP1_PRESET 8'h01
`define VPECS_HINT_RESET 32'h00000000
`define VPECS_FBACK_RESET 32'h00000000
`define VPECS_OPT_RESET 16'h0000
`define VPECS_YQ_RESET 31'h00000000
`define VPECS_SHARE_FULL 8'hFF
`endif

/* hw/vpecs_pkg.sv */
package vpecs_pkg;
    typedef struct packed {
        logic [7:0] udi_context_count;
        logic [7:0] cop2_context_count;
        logic [7:0] cop1_context_count;
        logic [30:0] thread_instr_a_qualifier_mask;
        logic [31:0] sched_hint;
        logic [31:0] sched_feedback;
        logic [15:0] cache_way_options;
    } vpecs_regs_t;
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [2:0] sel;
        logic [31:0] wdata;
    } vpecs_acc_t;
    typedef struct packed {
        logic [31:0] rdata;
        logic rd_valid;
        logic exc;
        logic [3:0] cause;
        logic [7:0] share;
    } vpecs_top_t;
endpackage

/* hw/vpecs_vpe_slice.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vpecs_defines.svh"
module vpecs_vpe_slice #(
    parameter int QUAL_INPUTS = `VPECS_QUAL_INPUTS,
    parameter logic [7:0] UDI_PRESET = `VPECS_UDI_PRESET,
    parameter logic [7:0] COP2_PRESET = `VPECS_COP2_PRESET,
    parameter logic [7:0] COP1_PRESET = `VPECS_COP1_PRESET
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register access for this copy
    input wire logic wr_en,
    input wire logic [2:0] sel,
    input wire logic [31:0] wdata,
    input wire logic config_write_enable,
    // scheduler event
    input wire logic retire_inc,
    // state
    output vpecs_pkg::vpecs_regs_t regs
);
    vpecs_pkg::vpecs_regs_t state;
    vpecs_pkg::vpecs_regs_t next_state;
    logic [30:0] impl_mask;

    always_comb begin
        for (int i = 0; i < `VPECS_YQ_W; i++) begin
            impl_mask[i] = (i < QUAL_INPUTS);
        end
    end

    always_comb begin
        next_state = state;
        if (wr_en && config_write_enable && sel == `VPECS_SEL_CONFIG) begin
            next_state.udi_context_count = wdata[`VPECS_UDI_LSB +: 8];
            next_state.cop2_context_count = wdata[`VPECS_COP2_LSB +: 8];
            next_state.cop1_context_count = wdata[`VPECS_COP1_LSB +: 8];
        end
        if (wr_en && sel == `VPECS_SEL_THREAD_INSTR_A_QUALIFIER_MASK) begin
            next_state.thread_instr_a_qualifier_mask = wdata[30:0] & impl_mask;
        end
        if (wr_en && sel == `VPECS_SEL_HINT) begin
            next_state.sched_hint = wdata;
        end
        // write loads, retirement still counted in same cycle
        if (wr_en && sel == `VPECS_SEL_FBACK) begin
            next_state.sched_feedback = wdata + {31'h00000000, retire_inc};
        end else begin
            next_state.sched_feedback = state.sched_feedback + {31'h00000000, retire_inc};
        end
        if (wr_en && sel == `VPECS_SEL_OPT) begin
            next_state.cache_way_options = wdata[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state.udi_context_count <= UDI_PRESET;
            state.cop2_context_count <= COP2_PRESET;
            state.cop1_context_count <= COP1_PRESET;
            state.thread_instr_a_qualifier_mask <= `VPECS_YQ_RESET;
            state.sched_hint <= `VPECS_HINT_RESET;
            state.sched_feedback <= `VPECS_FBACK_RESET;
            state.cache_way_options <= `VPECS_OPT_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign regs = state;
endmodule // vpecs_vpe_slice
`default_nettype wire

/* tb/vpecs_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module vpecs_regs_checker #(
    parameter int NUM_VPE = 2,
    parameter int QUAL_INPUTS = 31,
    localparam int VW = (NUM_VPE > 1) ? $clog2(NUM_VPE) : 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // watched ports
    input wire vpecs_pkg::vpecs_acc_t acc,
    input wire logic [VW-1:0] acc_vpe,
    input wire logic [31:0] rdata,
    input wire logic rd_valid,
    input wire logic thread_instr_a_valid,
    input wire logic [31:0] source_operand,
    input wire logic thread_exc,
    input wire logic [3:0] thread_exc_cause,
    input wire logic [NUM_VPE*32-1:0] sched_hint,
    input wire logic [NUM_VPE*8-1:0] icache_way_exclude,
    input wire logic [NUM_VPE*8-1:0] dcache_way_exclude
);
    localparam logic [30:0] QM = (31'h1 << QUAL_INPUTS) - 31'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    sequence s_rd(logic [2:0] s);
        acc.rd_en && acc.sel == s;
    endsequence
    sequence s_mask_wr_rd;
        acc.wr_en && acc.sel == 3'h4 && acc_vpe == '0 ##1 !acc.wr_en
            ##1 acc.rd_en && acc.sel == 3'h4 && acc_vpe == '0;
    endsequence
    a_read_valid: assert property (acc.rd_en |=> rd_valid) else $error("no read valid");
    a_cfg_reserved: assert property (s_rd(3'h3) |=> rdata[31:28] == 4'h0 &&
        rdata[19:18] == 2'h0 && rdata[9:8] == 2'h0) else $error("config reserved set");
    a_mask_msb: assert property (s_rd(3'h4) |=> !rdata[31]) else $error("mask bit 31 set");
    a_opt_upper: assert property (s_rd(3'h7) |=> rdata[31:16] == 16'h0)
        else $error("options upper set");
    a_mask_rw: assert property (s_mask_wr_rd |=>
        rdata[30:0] == ($past(acc.wdata[30:0], 3) & QM)) else $error("mask readback");
    a_exc_cause: assert property (thread_exc |-> thread_exc_cause == 4'h3 &&
        $past(thread_instr_a_valid)) else $error("exception cause");
    a_no_trap: assert property ((!thread_instr_a_valid || source_operand[31] ||
        source_operand == 32'h0) |=> !thread_exc) else $error("spurious exception");
    a_way_split: assert property (acc.wr_en && acc.sel == 3'h7 && acc_vpe == '0 |=>
        icache_way_exclude[7:0] == $past(acc.wdata[15:8]) &&
        dcache_way_exclude[7:0] == $past(acc.wdata[7:0])) else $error("way exclude");
    a_hint_wr: assert property (acc.wr_en && acc.sel == 3'h5 && acc_vpe == '0 |=>
        sched_hint[31:0] == $past(acc.wdata)) else $error("hint write");
endmodule // vpecs_regs_checker
bind vpecs_regs vpecs_regs_checker #(.NUM_VPE(NUM_VPE), .QUAL_INPUTS(QUAL_INPUTS)) u_chk (
    .sys_clk, .srst, .acc, .acc_vpe, .rdata, .rd_valid, .thread_instr_a_valid, .source_operand,
    .thread_exc, .thread_exc_cause, .sched_hint, .icache_way_exclude, .dcache_way_exclude
);
`default_nettype wire

/* tb/vpecs_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "vpecs_defines.svh"
module vpecs_regs_tb;
    logic sys_clk = 1'b0;
    logic srst, config_write_enable, rd_valid, thread_instr_a_valid, thread_exc;
    logic [0:0] acc_vpe, thread_instr_a_vpe, thread_vpe;
    logic [1:0] retire_inc;
    logic [3:0] thread_exc_cause;
    logic [7:0] thread_sched_hint, thread_issue_share;
    logic [15:0] icache_way_exclude, dcache_way_exclude, p;
    logic [31:0] rdata, source_operand, d;
    logic [63:0] sched_hint;
    logic [31:0] m [2][8];
    vpecs_pkg::vpecs_acc_t acc;
    int errors, tests_run;
    always #10 sys_clk = ~sys_clk;
    vpecs_regs #(.QUAL_INPUTS(24)) u_vpecs_regs (
        .sys_clk, .srst, .acc, .acc_vpe, .config_write_enable, .rdata, .rd_valid,
        .thread_instr_a_valid, .thread_instr_a_vpe, .source_operand, .thread_exc, .thread_exc_cause,
        .retire_inc, .thread_vpe, .thread_sched_hint, .thread_issue_share,
        .sched_hint, .icache_way_exclude, .dcache_way_exclude
    );
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [0:0] v, input logic [2:0] s, input logic [31:0] x);
        @(negedge sys_clk);
        acc = '{1'b1, 1'b0, s, x};
        acc_vpe = v;
        @(negedge sys_clk);
        acc.wr_en = 1'b0;
    endtask
    task automatic rd(input logic [0:0] v, input logic [2:0] s, input string n);
        @(negedge sys_clk);
        acc = '{1'b0, 1'b1, s, 32'h0};
        acc_vpe = v;
        @(negedge sys_clk);
        chk("rd_valid", {31'h0, rd_valid}, 32'h1);
        chk(n, rdata, m[v][s]);
        acc.rd_en = 1'b0;
    endtask
    task automatic yld(input logic [0:0] v, input logic [31:0] x);
        logic bad;
        bad = !x[31] && x != 32'h0 && |(x[30:0] & ~m[v][4][30:0]);
        @(negedge sys_clk);
        thread_instr_a_valid = 1'b1;
        thread_instr_a_vpe = v;
        source_operand = x;
        @(negedge sys_clk);
        chk("exc", {31'h0, thread_exc}, {31'h0, bad});
        chk("cause", {28'h0, thread_exc_cause}, bad ? 32'h3 : 32'h0);
        thread_instr_a_valid = 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish;
    end
    initial begin
        d = $urandom(38244);
        {srst, config_write_enable, thread_instr_a_valid, retire_inc} = 5'h10;
        {acc, acc_vpe, thread_instr_a_vpe, thread_vpe, thread_sched_hint, source_operand} = '0;
        foreach (m[v, s]) m[v][s] = 32'h0;
        m[0][3] = {4'h0, `VPECS_UDI_PRESET, 2'h0, `VPECS_COP2_PRESET, 2'h0, `VPECS_COP1_PRESET};
        m[1][3] = m[0][3];
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(i[0], 3'(3 + i / 2), "reset");
        end
        rd(1'b0, 3'h0, "unmapped");
        wr(1'b0, 3'h3, 32'h0FF3FCFF);
        rd(1'b0, 3'h3, "cfg locked");
        @(negedge sys_clk);
        config_write_enable = 1'b1;
        d = $urandom & 32'h0FF3FCFF;
        m[1][3] = d;
        wr(1'b1, 3'h3, d);
        rd(1'b1, 3'h3, "cfg open");
        rd(1'b0, 3'h3, "cfg other");
        @(negedge sys_clk);
        config_write_enable = 1'b0;
        for (int i = 0; i < 30; i++) begin
            logic [0:0] v;
            logic [2:0] s;
            v = 1'($urandom);
            s = 3'(4 + $urandom % 4);
            d = $urandom & (s == 3'h4 ? 32'h7FFFFFFF : s == 3'h7 ? 32'h0000FFFF : 32'hFFFFFFFF);
            wr(v, s, d);
            m[v][s] = s == 3'h4 ? d & 32'h00FFFFFF : d;
            rd(v, s, "reg");
            rd(~v, s, "other");
            chk("hint", sched_hint[v*32+:32], m[v][5]);
            chk("iwx", {24'h0, icache_way_exclude[v*8+:8]}, {24'h0, m[v][7][15:8]});
            chk("dwx", {24'h0, dcache_way_exclude[v*8+:8]}, {24'h0, m[v][7][7:0]});
        end
        @(negedge sys_clk);
        retire_inc = 2'b10;
        @(negedge sys_clk);
        retire_inc = 2'b00;
        m[1][6] = m[1][6] + 32'h1;
        rd(1'b1, 3'h6, "fback");
        rd(1'b0, 3'h6, "fback other");
        m[0][4] = 32'h00F000F0;
        wr(1'b0, 3'h4, m[0][4]);
        yld(1'b0, 32'h0);
        yld(1'b0, 32'h80000001);
        yld(1'b0, 32'h01000000);
        yld(1'b0, 32'h00100010);
        for (int i = 0; i < 24; i++) begin
            yld(1'($urandom), $urandom & (i[0] ? 32'h00F000F0 : 32'hFFFFFFFF));
        end
        m[0][5] = 32'h0;
        wr(1'b0, 3'h5, 32'h0);
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            thread_vpe = 1'(i);
            thread_sched_hint = 8'($urandom);
            @(posedge sys_clk);
            #1;
            d = m[thread_vpe][5];
            p = (d[7:0] == 8'h0 ? 16'h00FF : {8'h0, d[7:0]}) * thread_sched_hint;
            chk("share", {24'h0, thread_issue_share}, {24'h0, p[15:8]});
        end
        // second reset in mid-run
        @(negedge sys_clk);
        srst = 1'b1;
        @(negedge sys_clk);
        srst = 1'b0;
        foreach (m[v, s]) m[v][s] = (s == 3) ? m[0][3] : 32'h0;
        for (int i = 0; i < 10; i++) begin
            rd(i[0], 3'(3 + i / 2), "rereset");
        end
        tally_and_finish;
    end
endmodule // vpecs_regs_tb
`default_nettype wire
